/* File: sdj_timer.v */
// Off-delay, on-delay and jog timing controller with AHB-Lite register slave
// Operation
// R01 - Three functions: off-delay, on-delay, jog
// R02 - Flash link indicator while timing runs
// R03 - Open strap: non-retriggerable, starts on link drop
// R04 - Non-retriggerable delay always runs full time
// R05 - Outputs on promptly when link asserts
// R06 - Reassert during non-retrig delay flags fault
// R07 - Fault clears shortly after next link drop
// R08 - Drop during delay: fault clears at expiry
// R09 - Installer straps jog input before configuration
// R10 - Retrig: reassert zeroes timer, no fault
// R11 - Outputs off when off-delay expires
// R12 - On-delay starts when link asserts
// R13 - On-delay: on at expiry, off on drop
// R14 - Early drop: outputs off, timer zeroed
// R15 - Any interruption restarts on-delay from zero
// R16 - Jog time taken from captured settings
// R17 - Jog starts when both inputs asserted
// R18 - Jog expiry: off, fixed 500 ms lockout
// R19 - Early release: outputs off, start lockout
// R20 - Toggle in lockout keeps outputs off
// R21 - New jog needs an input held off
// R22 - Link held: next jog press repeats
// R23 - Jog flash 1 Hz on, 8 Hz lockout
// R24 - Tick-based timers, synced inputs, reset clear
//
// Chosen here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`include "sdj_regs.vh"
module sdj_timer #(
  parameter TICK_CYC = `SDJ_TICK_CYC,
  parameter TW = 20
) (
  input wire SYS_CLK,
  input wire RST,
  input wire LINK_IN,
  input wire JOG_IN,
  input wire HSEL,
  input wire [7:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire HREADY,
  input wire [31:0] HWDATA,
  output reg [31:0] HRDATA,
  output wire HREADYOUT,
  output wire HRESP,
  output reg SAFETY_OUT,
  output reg LINK_LED,
  output reg FAULT_RED
);
  // ****************************************************************
  // States
  // ****************************************************************
  localparam ST_IDLE = 6'b000001;
  localparam ST_RUN = 6'b000010;
  localparam ST_TIME = 6'b000100;
  localparam ST_HOLD = 6'b001000;
  localparam ST_LOCK = 6'b010000;
  localparam ST_WAIT = 6'b100000;
  localparam [31:0] JOG_OFF_W = `SDJ_JOG_OFF_MS;
  localparam [31:0] FL1_W = `SDJ_FLASH_1HZ_MS;
  localparam [31:0] FL8_W = `SDJ_FLASH_8HZ_MS;
  localparam [31:0] FLTC_W = `SDJ_FLT_CLR_MS;
  localparam [31:0] TIME_RST_W = `SDJ_TIME_RST;
  // Cut to the timer width on purpose; TW must hold the largest count
  localparam [TW-1:0] JOG_OFF = JOG_OFF_W[TW-1:0];
  localparam [TW-1:0] FL1 = FL1_W[TW-1:0];
  localparam [TW-1:0] FL8 = FL8_W[TW-1:0];
  localparam [TW-1:0] FLTC = FLTC_W[TW-1:0];
  localparam [TW-1:0] TIME_RST = TIME_RST_W[TW-1:0];

  wire tick;
  wire link;
  wire jog;
  // ****************************************************************
  // Input sync and tick
  // ****************************************************************
  // R24 synced inputs
  sdj_sync u_sl (.clk(SYS_CLK), .rst(RST), .d(LINK_IN), .q(link));
  sdj_sync u_sj (.clk(SYS_CLK), .rst(RST), .d(JOG_IN), .q(jog));
  // R24 fixed tick
  sdj_tick #(.DIV(TICK_CYC)) u_tk (.clk(SYS_CLK), .rst(RST), .tick(tick));

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg [1:0] mode_r;
  reg retrig_r;
  reg [TW-1:0] dly_r;
  reg [TW-1:0] time_r;
  reg cfg_req_r;
  reg [5:0] st_r;
  reg [TW-1:0] cnt_r;
  reg fault_r;
  reg fclr_r;
  reg [TW-1:0] fcnt_r;
  reg link_d_r;
  reg [TW-1:0] fl_r;
  reg [2:0] blink_r;
  reg [TW-1:0] bcnt_r;
  reg wr_ph_r;
  reg rd_ph_r;
  reg [7:0] addr_r;

  wire link_rise = link & ~link_d_r;
  wire link_fall = ~link & link_d_r;
  wire cnt_done = (cnt_r >= dly_r);
  wire lock_done = (cnt_r >= JOG_OFF);
  wire [TW-1:0] cnt_inc = cnt_r + {{(TW-1){1'b0}}, tick};

  // ****************************************************************
  // AHB-Lite slave: zero wait states, always OKAY
  // ****************************************************************
  wire ap = HSEL & HREADY & HTRANS[1];
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  always @(posedge SYS_CLK) begin
    if (RST) begin
      wr_ph_r <= 1'b0;
      rd_ph_r <= 1'b0;
      addr_r <= 8'h00;
    end else begin
      wr_ph_r <= ap & HWRITE;
      rd_ph_r <= ap & ~HWRITE;
      addr_r <= HADDR;
    end
  end

  // Config capture: mode is sampled on every control write, strap only on a config write
  always @(posedge SYS_CLK) begin
    if (RST) begin
      mode_r <= `SDJ_MODE_OFFD;
      retrig_r <= 1'b0;
      time_r <= TIME_RST;
      dly_r <= TIME_RST;
      cfg_req_r <= 1'b0;
    end else begin
      cfg_req_r <= 1'b0;
      if (wr_ph_r && addr_r == `SDJ_OFF_CTRL) begin
        mode_r <= HWDATA[`SDJ_CTRL_MODE_MSB:`SDJ_CTRL_MODE_LSB];
        cfg_req_r <= HWDATA[`SDJ_CTRL_CFG_BIT];
      end
      if (wr_ph_r && addr_r == `SDJ_OFF_TIME)
        time_r <= HWDATA[TW-1:0];
      // R03 strap captured at config
      // R16 jog time captured
      if (cfg_req_r) begin
        retrig_r <= jog;
        dly_r <= time_r;
      end
    end
  end

  always @(posedge SYS_CLK) begin
    if (RST)
      HRDATA <= 32'h0000_0000;
    else if (ap & ~HWRITE) begin
      case (HADDR)
        `SDJ_OFF_CTRL: HRDATA <= {29'h0, 1'b0, mode_r};
        `SDJ_OFF_TIME: HRDATA <= {{(32-TW){1'b0}}, time_r};
        `SDJ_OFF_STAT: HRDATA <= {24'h0, retrig_r, fault_r, SAFETY_OUT, st_r[4:0]};
        `SDJ_OFF_CNT: HRDATA <= {{(32-TW){1'b0}}, cnt_r};
        default: HRDATA <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // Timing state machine
  // ****************************************************************
  // R01 three modes
  always @(posedge SYS_CLK) begin
    if (RST) begin
      // R24 reset clears timers
      st_r <= ST_IDLE;
      cnt_r <= {TW{1'b0}};
      SAFETY_OUT <= 1'b0;
      link_d_r <= 1'b0;
    end else begin
      link_d_r <= link;
      case (st_r)
        ST_IDLE: begin
          cnt_r <= {TW{1'b0}};
          if (mode_r == `SDJ_MODE_JOG) begin
            // R17 both asserted
            if (link & jog) begin
              st_r <= ST_RUN;
              SAFETY_OUT <= 1'b1;
            end
          end else if (link && !fault_r) begin
            // R07 held off on fault
            // R05 prompt turn on
            // R12 on-delay starts
            st_r <= (mode_r == `SDJ_MODE_ON) ? ST_TIME : ST_HOLD;
            SAFETY_OUT <= (mode_r != `SDJ_MODE_ON);
          end
        end
        ST_HOLD: begin
          cnt_r <= {TW{1'b0}};
          if (mode_r == `SDJ_MODE_ON) begin
            // R13 off on drop
            if (!link) begin
              st_r <= ST_IDLE;
              SAFETY_OUT <= 1'b0;
            end
          end else if (link_fall) begin
            // R03 start on drop
            st_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          cnt_r <= cnt_inc;
          if (mode_r == `SDJ_MODE_JOG) begin
            // R19 early release
            // R18 jog expiry
            if (!link || !jog || cnt_done) begin
              st_r <= ST_LOCK;
              SAFETY_OUT <= 1'b0;
              cnt_r <= {TW{1'b0}};
            end
          end else if (retrig_r && link) begin
            // R10 retrigger zeroes timer
            st_r <= ST_HOLD;
            cnt_r <= {TW{1'b0}};
          end else if (cnt_done) begin
            // R04 full duration
            // R11 off at expiry
            st_r <= ST_IDLE;
            SAFETY_OUT <= 1'b0;
          end
        end
        ST_TIME: begin
          cnt_r <= cnt_inc;
          // R14 early drop zeroes
          // R15 restart from zero
          if (!link) begin
            st_r <= ST_IDLE;
            cnt_r <= {TW{1'b0}};
          end else if (cnt_done) begin
            // R13 on at expiry
            st_r <= ST_HOLD;
            SAFETY_OUT <= 1'b1;
          end
        end
        ST_LOCK: begin
          cnt_r <= cnt_inc;
          // R20 outputs stay off
          if (lock_done) begin
            st_r <= ST_WAIT;
            cnt_r <= {TW{1'b0}};
          end
        end
        ST_WAIT: begin
          // R21 one input must be off
          // R22 repeat on next press
          if (!link || !jog)
            st_r <= ST_IDLE;
        end
        default: begin
          st_r <= ST_IDLE;
          SAFETY_OUT <= 1'b0;
        end
      endcase
      if (mode_r != `SDJ_MODE_JOG && (st_r == ST_LOCK || st_r == ST_WAIT))
        st_r <= ST_IDLE;
    end
  end

  // ****************************************************************
  // Recoverable fault
  // ****************************************************************
  wire nr_run = (st_r == ST_RUN) & ~retrig_r & (mode_r == `SDJ_MODE_OFFD);
  always @(posedge SYS_CLK) begin
    if (RST) begin
      fault_r <= 1'b0;
      fclr_r <= 1'b0;
      fcnt_r <= {TW{1'b0}};
    end else begin
      // R06 reassert flags fault
      if (nr_run & link_rise)
        fault_r <= 1'b1;
      // R08 drop in delay, clear at expiry
      else if (fault_r && nr_run && cnt_done && !link)
        fault_r <= 1'b0;
      // R07 clear after next drop
      else if (fclr_r && fcnt_r >= FLTC)
        fault_r <= 1'b0;
      if (fault_r && st_r == ST_IDLE && link_fall) begin
        fclr_r <= 1'b1;
        fcnt_r <= {TW{1'b0}};
      end else if (fclr_r) begin
        fcnt_r <= fcnt_r + {{(TW-1){1'b0}}, tick};
        if (fcnt_r >= FLTC)
          fclr_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Indicators
  // ****************************************************************
  // Timing flashes slow except lockout; off-delay and on-delay share 1 Hz
  wire timing = (st_r == ST_RUN) | (st_r == ST_TIME) | (st_r == ST_LOCK);
  wire [TW-1:0] half = (st_r == ST_LOCK) ? FL8 : FL1;
  always @(posedge SYS_CLK) begin
    if (RST) begin
      fl_r <= {TW{1'b0}};
      LINK_LED <= 1'b0;
    end else if (!timing) begin
      fl_r <= {TW{1'b0}};
      LINK_LED <= link;
    end else if (tick) begin
      // R02 flash while timing
      // R23 1 Hz / 8 Hz
      if (fl_r + {{(TW-1){1'b0}}, 1'b1} >= half) begin
        fl_r <= {TW{1'b0}};
        LINK_LED <= ~LINK_LED;
      end else
        fl_r <= fl_r + {{(TW-1){1'b0}}, 1'b1};
    end
  end

  // Red flashes four times then a pause; green is implied by power
  always @(posedge SYS_CLK) begin
    if (RST) begin
      blink_r <= 3'h0;
      bcnt_r <= {TW{1'b0}};
      FAULT_RED <= 1'b0;
    end else if (!fault_r) begin
      blink_r <= 3'h0;
      bcnt_r <= {TW{1'b0}};
      FAULT_RED <= 1'b0;
    end else if (tick) begin
      // R06 four red flashes
      if (bcnt_r >= FL8 + FL8) begin
        bcnt_r <= {TW{1'b0}};
        blink_r <= blink_r + 3'h1;
      end else
        bcnt_r <= bcnt_r + {{(TW-1){1'b0}}, 1'b1};
      FAULT_RED <= (blink_r < 3'h4) && (bcnt_r < FL8);
    end
  end
endmodule // sdj_timer

/* File: sdj_regs.vh */
// Register map, field positions, reset values and timing constants of the delay/jog timer
`ifndef SDJ_REGS_VH
`define SDJ_REGS_VH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define SDJ_OFF_CTRL 8'h00
`define SDJ_OFF_TIME 8'h04
`define SDJ_OFF_STAT 8'h08
`define SDJ_OFF_CNT 8'h0C
// ****************************************************************
// Control fields
// ****************************************************************
`define SDJ_CTRL_MODE_LSB 0
`define SDJ_CTRL_MODE_MSB 1
`define SDJ_CTRL_CFG_BIT 2
`define SDJ_CTRL_RST 32'h0000_0000
`define SDJ_TIME_RST 32'h0000_000A
// ****************************************************************
// Mode encodings
// ****************************************************************
`define SDJ_MODE_OFFD 2'h0
`define SDJ_MODE_ON 2'h1
`define SDJ_MODE_JOG 2'h2
// ****************************************************************
// Timing
// ****************************************************************
`define SDJ_CLK_HZ 10000000
`define SDJ_TICK_MS 1
`define SDJ_TICK_CYC ((`SDJ_CLK_HZ / 1000) * `SDJ_TICK_MS)
`define SDJ_JOG_OFF_MS 500
`define SDJ_FLASH_1HZ_MS 500
`define SDJ_FLASH_8HZ_MS 62
`define SDJ_FLT_CLR_MS 10
`endif

/* File: sdj_sync.v */
// Two-flop synchroniser for one level input
`timescale 1ns/100ps
module sdj_sync (
  input wire clk,
  input wire rst,
  input wire d,
  output wire q
);
  reg s1_r;
  reg s2_r;
  always @(posedge clk) begin
    if (rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
    end
  end
  assign q = s2_r;
endmodule // sdj_sync

/* File: sdj_tick.v */
// Millisecond tick divider: one-cycle enable pulse
`timescale 1ns/100ps
module sdj_tick #(
  parameter DIV = 10000
) (
  input wire clk,
  input wire rst,
  output reg tick
);
  reg [15:0] cnt_r;
  always @(posedge clk) begin
    if (rst) begin
      cnt_r <= 16'h0000;
      tick <= 1'b0;
    end else if (cnt_r == DIV[15:0] - 16'h0001) begin
      cnt_r <= 16'h0000;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule // sdj_tick

/* File: sdj_timer_assertions.sv */
// Port-level checker for the delay/jog timer
`timescale 1ns/100ps
`include "sdj_regs.vh"
module sdj_timer_chk #(
  parameter TICK_CYC = `SDJ_TICK_CYC
) (
  input wire SYS_CLK,
  input wire RST,
  input wire LINK_IN,
  input wire JOG_IN,
  input wire HSEL,
  input wire [7:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire HREADY,
  input wire [31:0] HWDATA,
  input wire SAFETY_OUT,
  input wire FAULT_RED
);
  // One tick of slack: the lockout need not start on a tick boundary
  localparam int LOCK = (`SDJ_JOG_OFF_MS - 1) * TICK_CYC;
  reg wph_r;
  reg [1:0] mode_r;
  reg strap_r;
  reg [31:0] off_cnt_r;
  // ****************************************************************
  // Shadow of mode and strap, off-time counter
  // ****************************************************************
  // A control write sets the off-time count to its all-ones ceiling so a mode change is not judged
  always @(posedge SYS_CLK) begin
    wph_r <= !RST && HSEL && HREADY && HTRANS[1] && HWRITE && HADDR == `SDJ_OFF_CTRL;
    if (RST) mode_r <= 2'h0;
    else if (wph_r) mode_r <= HWDATA[1:0];
    if (RST) strap_r <= 1'b0;
    else if (wph_r && HWDATA[2]) strap_r <= JOG_IN;
    if (RST || wph_r) off_cnt_r <= 32'hFFFF_FFFF;
    else if (SAFETY_OUT) off_cnt_r <= 32'h0000_0000;
    else if (off_cnt_r != 32'hFFFF_FFFF) off_cnt_r <= off_cnt_r + 32'h0000_0001;
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  property p_rst; disable iff (1'b0) RST |=> !SAFETY_OUT && !FAULT_RED; endproperty
  a_rst: assert property (p_rst) else $error("outputs active after reset");
  property p_rise; $rose(SAFETY_OUT) |-> $past(LINK_IN, 2); endproperty
  a_rise: assert property (p_rise) else $error("outputs rose without link");
  property p_offd_on; mode_r == `SDJ_MODE_OFFD && $rose(LINK_IN) |-> ##[1:6] SAFETY_OUT; endproperty
  a_offd_on: assert property (p_offd_on) else $error("off-delay outputs late on");
  property p_retrig; mode_r == `SDJ_MODE_OFFD && strap_r |-> !FAULT_RED; endproperty
  a_retrig: assert property (p_retrig) else $error("fault shown in retrigger mode");
  property p_on_wait; mode_r == `SDJ_MODE_ON && $rose(LINK_IN) |=> !SAFETY_OUT [*8]; endproperty
  a_on_wait: assert property (p_on_wait) else $error("on-delay outputs early");
  property p_on_drop; mode_r == `SDJ_MODE_ON && $fell(LINK_IN) |-> ##[1:5] !SAFETY_OUT; endproperty
  a_on_drop: assert property (p_on_drop) else $error("on-delay outputs stay on");
  property p_jog_drop; mode_r == `SDJ_MODE_JOG && $fell(JOG_IN) |-> ##[1:5] !SAFETY_OUT; endproperty
  a_jog_drop: assert property (p_jog_drop) else $error("jog outputs stay on");
  property p_jog_lock; mode_r == `SDJ_MODE_JOG && $rose(SAFETY_OUT) |-> off_cnt_r >= LOCK; endproperty
  a_jog_lock: assert property (p_jog_lock) else $error("jog restarted in lockout");
endmodule // sdj_timer_chk
bind sdj_timer sdj_timer_chk #(.TICK_CYC(TICK_CYC)) i_chk (
  .SYS_CLK(SYS_CLK), .RST(RST), .LINK_IN(LINK_IN), .JOG_IN(JOG_IN), .HSEL(HSEL),
  .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HWDATA(HWDATA),
  .SAFETY_OUT(SAFETY_OUT), .FAULT_RED(FAULT_RED));

/* File: sdj_link_src.sv */
// Upstream relay model driving the logic link level
`timescale 1ns/100ps
module sdj_link_src (
  input wire clk,
  input wire want,
  input wire slow,
  output reg link
);
  reg [2:0] wait_r = 3'h0;
  // ****************************************************************
  // Link driver
  // ****************************************************************
  // Slow mode mimics a sluggish upstream output stage
  initial link = 1'b0;
  always @(posedge clk) begin
    if (want == link) wait_r <= 3'h0;
    else if (!slow || wait_r == 3'h5) link <= want;
    else wait_r <= wait_r + 3'h1;
  end
endmodule // sdj_link_src

/* File: sdj_timer_tb.sv */
// Self-checking bench for the delay/jog timer
`timescale 1ns/100ps
`include "sdj_regs.vh"
module sdj_timer_tb;
  logic SYS_CLK = 1'b0;
  logic RST = 1'b1;
  logic JOG_IN = 1'b0;
  logic want = 1'b0;
  logic slow = 1'b0;
  logic [7:0] HADDR = 8'h00;
  logic [1:0] HTRANS = 2'h0;
  logic HWRITE = 1'b0;
  logic [31:0] HWDATA = 32'h0;
  logic rd_pend = 1'b0;
  logic [31:0] exp_q[$];
  logic [15:0] rnd = 16'h003D;
  int failures = 0;
  int cmp_count = 0;
  logic led_q = 1'b0;
  int led_tg = 0;
  int led_n0 = 0;
  wire LINK_IN, HREADYOUT, HRESP, SAFETY_OUT, LINK_LED, FAULT_RED;
  wire [31:0] HRDATA;
  wire [31:0] so_w = {31'h0, SAFETY_OUT};
  wire [31:0] fr_w = {31'h0, FAULT_RED};
  always #50 SYS_CLK = ~SYS_CLK;
  sdj_link_src i_src (.clk(SYS_CLK), .want(want), .slow(slow), .link(LINK_IN));
  // Short tick keeps the run brief; a tick is 10 cycles and every wait below except the time limit is in clock cycles
  sdj_timer #(.TICK_CYC(10), .TW(20)) i_dut (
    .SYS_CLK(SYS_CLK), .RST(RST), .LINK_IN(LINK_IN), .JOG_IN(JOG_IN), .HSEL(1'b1),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HREADY(HREADYOUT),
    .HWDATA(HWDATA), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .SAFETY_OUT(SAFETY_OUT), .LINK_LED(LINK_LED), .FAULT_RED(FAULT_RED));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge SYS_CLK);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    HADDR <= a;
    HWRITE <= w;
    HTRANS <= 2'h2;
    @(posedge SYS_CLK);
    while (HREADYOUT !== 1'b1) @(posedge SYS_CLK);
    HTRANS <= 2'h0;
    HWDATA <= d;
    @(posedge SYS_CLK);
    while (HREADYOUT !== 1'b1) @(posedge SYS_CLK);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Read data is judged at the edge that closes the data phase
  always @(posedge SYS_CLK) begin
    if (rd_pend && HREADYOUT && exp_q.size() > 0) chk(HRDATA, exp_q.pop_front());
    if (HREADYOUT) rd_pend <= HTRANS[1] && !HWRITE;
  end
  // Link indicator toggle count
  always @(posedge SYS_CLK) begin
    led_q <= LINK_LED;
    if (LINK_LED !== led_q) led_tg <= led_tg + 1;
  end
  initial begin
    #2000000;
    failures++;
    complete_run;
  end
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    cyc(10);
    RST <= 1'b0;
    rd(`SDJ_OFF_CTRL, `SDJ_CTRL_RST);
    rd(`SDJ_OFF_TIME, `SDJ_TIME_RST);
    rd(8'h10, 32'h0);
    rnd = lfsr(rnd);
    bus(`SDJ_OFF_TIME, 1'b1, {16'h0, rnd});
    rd(`SDJ_OFF_TIME, {16'h0, rnd});
    bus(`SDJ_OFF_TIME, 1'b1, 32'h5);
    bus(`SDJ_OFF_CTRL, 1'b1, 32'h4);
    rd(`SDJ_OFF_STAT, 32'h1);
    $display("test registers done");
    want <= 1'b1;
    cyc(10);
    chk(so_w, 32'h1);
    want <= 1'b0;
    cyc(20);
    want <= 1'b1;
    cyc(10);
    rd(`SDJ_OFF_STAT, 32'h62);
    want <= 1'b0;
    cyc(5);
    rd(`SDJ_OFF_STAT, 32'h62);
    cyc(40);
    chk(so_w, 32'h0);
    rd(`SDJ_OFF_STAT, 32'h1);
    want <= 1'b1;
    cyc(10);
    want <= 1'b0;
    cyc(20);
    want <= 1'b1;
    cyc(60);
    chk(so_w, 32'h0);
    chk(fr_w, 32'h1);
    rd(`SDJ_OFF_STAT, 32'h41);
    want <= 1'b0;
    cyc(150);
    rd(`SDJ_OFF_STAT, 32'h1);
    chk(fr_w, 32'h0);
    $display("test non-retriggerable done");
    slow <= 1'b1;
    JOG_IN <= 1'b1;
    cyc(5);
    bus(`SDJ_OFF_CTRL, 1'b1, 32'h4);
    JOG_IN <= 1'b0;
    // Strap lands one cycle after the capture strobe
    cyc(1);
    rd(`SDJ_OFF_STAT, 32'h81);
    want <= 1'b1;
    cyc(20);
    want <= 1'b0;
    cyc(30);
    want <= 1'b1;
    cyc(20);
    want <= 1'b0;
    cyc(40);
    chk(so_w, 32'h1);
    cyc(40);
    chk(so_w, 32'h0);
    slow <= 1'b0;
    $display("test retriggerable done");
    bus(`SDJ_OFF_CTRL, 1'b1, 32'h5);
    want <= 1'b1;
    cyc(30);
    chk(so_w, 32'h0);
    want <= 1'b0;
    cyc(10);
    chk(so_w, 32'h0);
    want <= 1'b1;
    cyc(40);
    chk(so_w, 32'h0);
    cyc(30);
    chk(so_w, 32'h1);
    want <= 1'b0;
    cyc(6);
    chk(so_w, 32'h0);
    $display("test on-delay done");
    bus(`SDJ_OFF_CTRL, 1'b1, {30'h0, `SDJ_MODE_JOG});
    want <= 1'b1;
    cyc(10);
    JOG_IN <= 1'b1;
    cyc(10);
    chk(so_w, 32'h1);
    cyc(60);
    chk(so_w, 32'h0);
    led_n0 = led_tg;
    JOG_IN <= 1'b0;
    cyc(5);
    JOG_IN <= 1'b1;
    cyc(5100);
    chk(so_w, 32'h0);
    // 500 ms at 8 Hz is eight half periods, one either way for phase
    chk({31'h0, ((led_tg - led_n0) >= 7 && (led_tg - led_n0) <= 9)}, 32'h1);
    JOG_IN <= 1'b0;
    cyc(10);
    JOG_IN <= 1'b1;
    cyc(10);
    chk(so_w, 32'h1);
    JOG_IN <= 1'b0;
    cyc(6);
    chk(so_w, 32'h0);
    cyc(5100);
    want <= 1'b0;
    $display("test jog done");
    cyc(5);
    complete_run;
  end
endmodule // sdj_timer_tb
